//--- hw/kpi_det_if.sv
`timescale 1ns/100ps
`default_nettype none

interface kpi_det_if #(
    parameter int NUM_PINS = 8
);
    logic [NUM_PINS-1:0] pin_enable;
    logic [NUM_PINS-1:0] polarity;
    logic level_mode;
    logic [NUM_PINS-1:0] trig;
    logic [NUM_PINS-1:0] level;

    modport control (
        output pin_enable,
        output polarity,
        output level_mode,
        input trig,
        input level
    );

    modport detector (
        input pin_enable,
        input polarity,
        input level_mode,
        output trig,
        output level
    );
endinterface : kpi_det_if

`default_nettype wire

//--- hw/kpi_detect.sv
`timescale 1ns/100ps
`default_nettype none

module kpi_detect
    import kpi_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int FIXED_PINS = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_PINS-1:0] key_pins,
    kpi_det_if.detector det
);

    logic [NUM_PINS-1:0] sync1_q, sync1_d;
    logic [NUM_PINS-1:0] sync2_q, sync2_d;
    logic [NUM_PINS-1:0] prev_q, prev_d;
    logic [NUM_PINS-1:0] trig;

    always_comb begin
        sync1_d = key_pins;
        sync2_d = sync1_q; // [RULE9]
        prev_d = sync2_q; // [RULE9]
        for (int i = 0; i < NUM_PINS; i++) begin
            if (i >= FIXED_PINS && det.polarity[i]) begin
                // rising edge or high level
                trig[i] = (sync2_q[i] & ~prev_q[i]) // [RULE1] [RULE9]
                    | (det.level_mode & sync2_q[i]); // [RULE3]
            end else begin
                // falling edge or low level, always so for low pins
                trig[i] = (~sync2_q[i] & prev_q[i]) // [RULE2] [RULE9]
                    | (det.level_mode & ~sync2_q[i]); // [RULE3]
            end
        end
        det.trig = trig & det.pin_enable; // [RULE8]
        det.level = sync2_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
        end
    end

endmodule : kpi_detect

`default_nettype wire

//--- hw/kpi_pkg.sv
package kpi_pkg;

    // key pin count and the low pins whose polarity is fixed to falling/low
    localparam int KPI_NUM_PINS = 8;
    localparam int KPI_FIXED_PINS = 4;

    // register byte offsets (low address byte)
    localparam logic [7:0] KPI_OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] KPI_OFS_PIN_ENABLE = 8'h04;
    localparam logic [7:0] KPI_OFS_EVENT_STATUS = 8'h08;
    localparam logic [7:0] KPI_OFS_EVENT_MASK = 8'h0c;
    localparam logic [7:0] KPI_OFS_PIN_LEVEL = 8'h10;

    // keypad_status_control field positions
    localparam int KPI_POL_LSB = 4;
    localparam int KPI_POL_MSB = 7;
    localparam int KPI_BIT_FLAG = 3;
    localparam int KPI_BIT_ACK = 2;
    localparam int KPI_BIT_IRQ_EN = 1;
    localparam int KPI_BIT_MODE = 0;

    // event status / mask layout
    localparam int KPI_NUM_EVENTS = 2;
    localparam int KPI_EVT_KEY = 0;
    localparam int KPI_EVT_ACK_HELD = 1;

    // reset values
    localparam logic [3:0] KPI_RST_POLARITY = 4'h0;
    localparam logic KPI_RST_FLAG = 1'b0;
    localparam logic KPI_RST_IRQ_EN = 1'b0;
    localparam logic KPI_RST_MODE = 1'b0;
    localparam logic [7:0] KPI_RST_PIN_ENABLE = 8'h00;
    localparam logic [1:0] KPI_RST_EVENT_STATUS = 2'h0;
    localparam logic [1:0] KPI_RST_EVENT_MASK = 2'h0;
    localparam logic [31:0] KPI_RST_HRDATA = 32'h0000_0000;

    // ahb encodings
    localparam logic [1:0] KPI_HTRANS_NONSEQ = 2'h2;
    localparam logic KPI_HRESP_OKAY = 1'b0;

    // bus slave phases
    typedef enum logic [1:0] {
        KPI_PH_IDLE,
        KPI_PH_WRITE,
        KPI_PH_READ_WAIT,
        KPI_PH_READ_DONE
    } kpi_phase_type;

endpackage : kpi_pkg

//--- hw/kpi_top.sv
// What this block does
// [RULE1] pins 7..4 enabled: polarity bit 0 falling/low, 1 rising/high
// [RULE2] pins 3..0 always falling edge or low level, polarity fixed
// [RULE3] mode bit 0 edge only, 1 edge and level, all pins
// [RULE4] pending flag bit 3 set on any enabled trigger, read only
// [RULE5] writing 1 to ack bit 2 clears flag; ack reads 0
// [RULE6] level mode with asserted pin keeps flag set over ack
// [RULE7] request irq while flag and irq enable bit 1 both 1
// [RULE8] only pins with enable bit 1 can set the flag
// [RULE9] pins synchronised; edge from current versus previous sample
// [RULE10] reset clears flag, irq enable, mode and polarity bits
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module kpi_top
    import kpi_pkg::*;
#(
    parameter int NUM_PINS = KPI_NUM_PINS,
    parameter int FIXED_PINS = KPI_FIXED_PINS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NUM_PINS-1:0] key_pins,
    output logic irq
);

    // bus slave state
    kpi_phase_type phase_q, phase_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] hrdata_q, hrdata_d;

    // configuration and status
    logic [3:0] polarity_q, polarity_d;
    logic flag_q, flag_d;
    logic irq_en_q, irq_en_d;
    logic mode_q, mode_d;
    logic [NUM_PINS-1:0] pin_en_q, pin_en_d;
    logic [KPI_NUM_EVENTS-1:0] evt_q, evt_d;
    logic [KPI_NUM_EVENTS-1:0] mask_q, mask_d;

    // decoded bus activity
    logic accept;
    logic wr_any;
    logic wr_sc;
    logic wr_pin_en;
    logic wr_evt;
    logic wr_mask;
    logic ack;
    logic any_trig;
    logic [KPI_NUM_EVENTS-1:0] evt_set;
    logic [31:0] read_value;

    kpi_det_if #(.NUM_PINS(NUM_PINS)) det ();

    kpi_detect #(
        .NUM_PINS(NUM_PINS),
        .FIXED_PINS(FIXED_PINS)
    ) u_detect (
        .clk(clk),
        .rst_n(rst_n),
        .key_pins(key_pins),
        .det(det)
    );

    // true when the latched address selects the given register
    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        reg_hit = (addr[7:2] == offset[7:2]);
    endfunction : reg_hit

    // polarity bits only reach the upper pins
    always_comb begin
        det.pin_enable = pin_en_q;
        det.polarity = '0;
        det.polarity[NUM_PINS-1 -: 4] = polarity_q; // [RULE1]
        det.level_mode = mode_q; // [RULE3]
    end

    // address phase acceptance and write decode
    always_comb begin
        accept = hsel && hready && (htrans == KPI_HTRANS_NONSEQ);
        wr_any = (phase_q == KPI_PH_WRITE);
        wr_sc = wr_any && reg_hit(addr_q, KPI_OFS_STATUS_CONTROL);
        wr_pin_en = wr_any && reg_hit(addr_q, KPI_OFS_PIN_ENABLE);
        wr_evt = wr_any && reg_hit(addr_q, KPI_OFS_EVENT_STATUS);
        wr_mask = wr_any && reg_hit(addr_q, KPI_OFS_EVENT_MASK);
        ack = wr_sc && hwdata[KPI_BIT_ACK]; // [RULE5]
        any_trig = |det.trig; // [RULE8]
    end

    // bus slave phase sequencing
    always_comb begin
        phase_d = phase_q;
        addr_d = addr_q;
        unique case (phase_q)
            KPI_PH_IDLE, KPI_PH_WRITE, KPI_PH_READ_DONE: begin
                if (accept) begin
                    addr_d = haddr[7:0];
                    if (hwrite) begin
                        phase_d = KPI_PH_WRITE;
                    end else begin
                        phase_d = KPI_PH_READ_WAIT;
                    end
                end else begin
                    phase_d = KPI_PH_IDLE;
                end
            end
            KPI_PH_READ_WAIT: begin
                phase_d = KPI_PH_READ_DONE;
            end
        endcase
    end

    // read multiplexer, sampled during the wait cycle
    always_comb begin
        read_value = '0;
        if (reg_hit(addr_q, KPI_OFS_STATUS_CONTROL)) begin
            read_value[KPI_POL_MSB:KPI_POL_LSB] = polarity_q;
            read_value[KPI_BIT_FLAG] = flag_q; // [RULE4]
            read_value[KPI_BIT_ACK] = 1'b0; // [RULE5]
            read_value[KPI_BIT_IRQ_EN] = irq_en_q;
            read_value[KPI_BIT_MODE] = mode_q;
        end else if (reg_hit(addr_q, KPI_OFS_PIN_ENABLE)) begin
            read_value[NUM_PINS-1:0] = pin_en_q;
        end else if (reg_hit(addr_q, KPI_OFS_EVENT_STATUS)) begin
            read_value[KPI_NUM_EVENTS-1:0] = evt_q;
        end else if (reg_hit(addr_q, KPI_OFS_EVENT_MASK)) begin
            read_value[KPI_NUM_EVENTS-1:0] = mask_q;
        end else if (reg_hit(addr_q, KPI_OFS_PIN_LEVEL)) begin
            read_value[NUM_PINS-1:0] = det.level;
        end
    end

    always_comb begin
        hrdata_d = hrdata_q;
        if (phase_q == KPI_PH_READ_WAIT) begin
            hrdata_d = read_value;
        end
    end

    // configuration registers
    always_comb begin
        polarity_d = polarity_q;
        irq_en_d = irq_en_q;
        mode_d = mode_q;
        pin_en_d = pin_en_q;
        mask_d = mask_q;
        if (wr_sc) begin
            polarity_d = hwdata[KPI_POL_MSB:KPI_POL_LSB]; // [RULE1]
            irq_en_d = hwdata[KPI_BIT_IRQ_EN]; // [RULE7]
            mode_d = hwdata[KPI_BIT_MODE]; // [RULE3]
        end
        if (wr_pin_en) begin
            pin_en_d = hwdata[NUM_PINS-1:0]; // [RULE8]
        end
        if (wr_mask) begin
            mask_d = hwdata[KPI_NUM_EVENTS-1:0];
        end
    end

    // pending flag: a trigger in the ack cycle wins over the clear
    always_comb begin
        flag_d = flag_q;
        if (ack) begin
            flag_d = 1'b0; // [RULE5]
        end
        if (any_trig) begin
            flag_d = 1'b1; // [RULE4] [RULE6]
        end
    end

    // sticky event bits, write one to clear, set wins
    always_comb begin
        evt_set = '0;
        evt_set[KPI_EVT_KEY] = any_trig && !flag_q;
        evt_set[KPI_EVT_ACK_HELD] = ack && any_trig; // [RULE6]
        evt_d = evt_q;
        if (wr_evt) begin
            evt_d = evt_q & ~hwdata[KPI_NUM_EVENTS-1:0];
        end
        evt_d = evt_d | evt_set;
    end

    // bus answers and interrupt line
    always_comb begin
        hreadyout = (phase_q != KPI_PH_READ_WAIT);
        hresp = KPI_HRESP_OKAY;
        hrdata = hrdata_q;
        irq = (flag_q && irq_en_q) // [RULE7]
            || (|(evt_q & mask_q));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_q <= KPI_PH_IDLE;
            addr_q <= 8'h00;
            hrdata_q <= KPI_RST_HRDATA;
        end else begin
            phase_q <= phase_d;
            addr_q <= addr_d;
            hrdata_q <= hrdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            polarity_q <= KPI_RST_POLARITY; // [RULE10]
            flag_q <= KPI_RST_FLAG; // [RULE10]
            irq_en_q <= KPI_RST_IRQ_EN; // [RULE10]
            mode_q <= KPI_RST_MODE; // [RULE10]
            pin_en_q <= KPI_RST_PIN_ENABLE;
            evt_q <= KPI_RST_EVENT_STATUS;
            mask_q <= KPI_RST_EVENT_MASK;
        end else begin
            polarity_q <= polarity_d;
            flag_q <= flag_d;
            irq_en_q <= irq_en_d;
            mode_q <= mode_d;
            pin_en_q <= pin_en_d;
            evt_q <= evt_d;
            mask_q <= mask_d;
        end
    end

endmodule : kpi_top

`default_nettype wire

//--- verification/kpi_keypad.sv
`timescale 1ns/100ps
`default_nettype none

module kpi_keypad (
    input wire logic [7:0] press,
    output logic [7:0] key_pins
);
    // a pressed key pulls its pin to ground, released pins sit at the pull-up
    assign key_pins = ~press;
endmodule : kpi_keypad

`default_nettype wire

//--- verification/kpi_top_props.sv
`timescale 1ns/100ps
`default_nettype none

module kpi_top_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq
);
    wire take = hsel && hready && htrans == 2'h2;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // read of the status and control word, up to its data cycle
    sequence s_rd0;
        take && !hwrite && haddr[7:2] == 6'h0 ##1 !hreadyout ##1 hreadyout;
    endsequence
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_wr; take && hwrite |=> hreadyout; endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_rdw; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rdw: assert property (p_rdw) else $error("read wait wrong");
    property p_idle; !take ##1 !take |-> hreadyout; endproperty
    a_idle: assert property (p_idle) else $error("stall while idle");
    property p_ack0; s_rd0 |-> hrdata[2] == 1'b0; endproperty
    a_ack0: assert property (p_ack0) else $error("ack reads one");
    property p_rsvd; s_rd0 |-> hrdata[31:8] == 24'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("upper bits set");
    property p_irq; s_rd0 ##0 (hrdata[3] && hrdata[1]) |-> irq; endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_rst; $rose(rst_n) |-> !irq && hrdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule : kpi_top_props

`default_nettype wire

//--- verification/kpi_top_test.sv
`timescale 1ns/100ps
`default_nettype none

module kpi_top_test
    import kpi_pkg::*;
;
    localparam logic [7:0] SC = KPI_OFS_STATUS_CONTROL;
    localparam logic [7:0] PE = KPI_OFS_PIN_ENABLE;
    localparam logic [7:0] ES = KPI_OFS_EVENT_STATUS;
    localparam logic [7:0] EM = KPI_OFS_EVENT_MASK;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] press = 8'h00;
    wire hreadyout;
    wire hresp;
    wire irq;
    wire [31:0] hrdata;
    wire [7:0] key_pins;
    int n_fail = 0;
    int n_compared = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    kpi_top u_dut (
        .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .key_pins, .irq
    );
    kpi_keypad u_pad (.press, .key_pins);

    task results();
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task wait_rdy();
        int i;
        i = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 20) begin
                n_fail++;
                results();
            end
            @(posedge clk);
        end
    endtask : wait_rdy

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= KPI_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rc

    // look at irq mid-cycle, then hand back on a rising edge
    task ci(input logic exp);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp});
        @(posedge clk);
    endtask : ci

    // pins pass two flops and an edge stage before the flag moves
    task keys(input logic [7:0] p);
        press <= p;
        repeat (5) @(posedge clk);
    endtask : keys

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(SC, 32'h0);
        rc(PE, 32'h0);
        rc(8'h14, 32'h0);
        rc(KPI_OFS_PIN_LEVEL, 32'hff);
        keys(8'h01);
        wr(PE, 32'h0f);
        rc(SC, 32'h0);
        keys(8'h00);
        rc(SC, 32'h0);
        wr(SC, 32'hf0);
        keys(8'h01);
        rc(SC, 32'hf8);
        ci(1'b0);
        rc(ES, 32'h1);
        wr(EM, 32'h1);
        ci(1'b1);
        wr(ES, 32'h1);
        ci(1'b0);
        rc(ES, 32'h0);
        wr(SC, 32'hf2);
        ci(1'b1);
        wr(SC, 32'hf6);
        keys(8'h01);
        rc(SC, 32'hf2);
        ci(1'b0);
        wr(SC, 32'hf3);
        keys(8'h01);
        wr(SC, 32'hf7);
        rc(SC, 32'hfb);
        keys(8'h00);
        wr(SC, 32'hf7);
        rc(SC, 32'hf3);
        rc(ES, 32'h3);
        wr(EM, 32'h0);
        wr(SC, 32'h82);
        wr(PE, 32'h80);
        keys(8'h20);
        keys(8'h00);
        rc(SC, 32'h82);
        ci(1'b0);
        keys(8'h80);
        rc(SC, 32'h82);
        keys(8'h00);
        rc(SC, 32'h8a);
        ci(1'b1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(SC, 32'h0);
        ci(1'b0);
        results();
    end
endmodule : kpi_top_test

bind kpi_top kpi_top_props u_props (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .irq
);

`default_nettype wire
